// ### hdl/rlf_pkg.sv
// package: register map, field positions, reset values and types
package rlf_pkg;
  // ************************************************************
  // register offsets (byte addresses)
  // ************************************************************
  localparam logic [11:0] OFS_MASK_CTRL = 12'h00C;
  localparam logic [11:0] OFS_FEATURES = 12'h010;
  localparam logic [11:0] OFS_STATUS = 12'h000;
  localparam logic [11:0] OFS_RING = 12'h020;
  // ************************************************************
  // mask/control register fields
  // ************************************************************
  localparam int MC_LOOKAHEAD = 5;
  localparam int MC_DEFER_DIS = 4;
  localparam int MC_MOD_BACKOFF = 3;
  // ************************************************************
  // features register fields
  // ************************************************************
  localparam int FT_TEST = 15;
  localparam int FT_BURST_DIS = 14;
  localparam int FT_TIMER = 13;
  localparam int FT_POLL_DIS = 12;
  localparam int FT_PAD = 11;
  localparam int FT_STRIP = 10;
  localparam int FT_MISS_OVF = 9;
  localparam int FT_MISS_MASK = 8;
  localparam int FT_COL_OVF = 5;
  localparam int FT_COL_MASK = 4;
  localparam int FT_TXS = 3;
  localparam int FT_TXS_MASK = 2;
  localparam int FT_JAB = 1;
  localparam int FT_JAB_MASK = 0;
  // ************************************************************
  // status register fields
  // ************************************************************
  localparam int ST_SUMMARY = 0;
  localparam int ST_RX_INT = 1;
  localparam int ST_TX_DEMAND = 2;
  localparam int ST_STOP = 3;
  // ************************************************************
  // reset values and widths
  // ************************************************************
  localparam logic [15:0] FEATURES_RST = 16'h0115;
  localparam logic [15:0] MASK_CTRL_RST = 16'h0000;
  localparam int PAD_MIN_BYTES = 64;
  localparam int RING_IDX_W = 7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ring descriptor view returned by the descriptor fetch engine
  typedef struct packed {
    logic own;
    logic start;
  } rlf_desc_t;

  // event strobes from the datapath
  typedef struct packed {
    logic miss_ovf;
    logic col_ovf;
    logic tx_start;
    logic jabber;
    logic twisted_pair;
    logic rx_first_done;
    logic rx_last_done;
  } rlf_evt_t;

  // feature controls driven to the datapath
  typedef struct packed {
    logic lookahead;
    logic defer_dis;
    logic mod_backoff;
    logic test_mode;
    logic burst_dis;
    logic timer_en;
    logic poll_dis;
    logic auto_pad;
    logic auto_strip;
  } rlf_ctrl_t;

  typedef enum logic [3:0] {
    SC_IDLE = 4'b0001,
    SC_FETCH = 4'b0010,
    SC_POLL = 4'b0100,
    SC_HOLD = 4'b1000
  } rlf_scan_t;
endpackage

// ### hdl/rlf_ctrl.sv
// rx look-ahead scan and feature control register bank
//
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/100ps
// Summary of operation
// - look-ahead: rx interrupt after first buffer too
// - look-ahead reads start flag to place packet
// - after last descriptor, scan to next start; done from idle only, a last buffer in hold just returns to idle
// - scan ignores ownership, clears own without start
// - host entry without start left untouched, skip
// - host-owned start entry: stop, poll periodically
// - device-owned start entry: stop, keep, wait
// - look-ahead bit rw, reset clears, stop keeps
// - deferral disable bit, reset clears, stop keeps
// - modified back-off bit rw, reset clears
// - test mode only on first features write
// - burst counter disable bit, reset clears
// - bus timer enable bit, reset clears
// - poll disable stops auto polling, demand needed
// - auto pad to 64 bytes, overrides checksum disable
// - auto strip removes pad and checksum
// - missed overflow flag w1c, mask set by reset
// - collision overflow flag w1c, cleared by stop
// - collision overflow mask set by reset
// - transmit start flag set at frame start
// - transmit start mask set by reset
// - jabber flag twisted-pair only, mask by reset
// - summary set by any unmasked cause
module rlf_ctrl #(
  parameter int POLL_CYCLES = 4096
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire rlf_pkg::rlf_evt_t evt,
  input wire logic stop_req,
  input wire logic transmitter_on,
  input wire logic tx_desc_fetched,
  input wire logic tx_checksum_disable,
  input wire logic desc_valid,
  input wire rlf_pkg::rlf_desc_t desc,
  output logic desc_fetch,
  output logic desc_own_clear,
  output logic [rlf_pkg::RING_IDX_W-1:0] ring_idx,
  output logic rx_buffer_ready,
  output rlf_pkg::rlf_ctrl_t ctrl,
  output logic tx_checksum_append,
  output logic tx_auto_poll,
  output logic tx_demand_poll,
  output logic interrupt_summary
);
  import rlf_pkg::*;

  // ************************************************************
  // bus slave
  // ************************************************************
  logic aw_held_r, w_held_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic do_wr;
  logic wr_feat, wr_mc, wr_stat;
  logic [15:0] wd;

  assign do_wr = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wd = wdata_r[15:0];
  // both low byte lanes must be enabled for a 16-bit field write
  assign wr_feat = do_wr && awaddr_r == OFS_FEATURES && &wstrb_r[1:0];
  assign wr_mc = do_wr && awaddr_r == OFS_MASK_CTRL && &wstrb_r[1:0];
  assign wr_stat = do_wr && awaddr_r == OFS_STATUS && wstrb_r[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 12'h000;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r <= {s_axi_awaddr[11:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awaddr_r == OFS_FEATURES || awaddr_r == OFS_MASK_CTRL ||
            awaddr_r == OFS_STATUS) begin
          s_axi_bresp <= RESP_OKAY;
        end else begin
          s_axi_bresp <= RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_held_r && !(s_axi_wvalid && s_axi_wready);
    end
  end

  // ************************************************************
  // control and flag state
  // ************************************************************
  logic [15:0] feat_r;
  logic [15:0] mc_r;
  logic first_feat_wr_r;
  logic stop_r;
  logic rx_int_r;
  logic demand_r;

  function automatic logic w1c_flag(input logic cur, input logic set,
                                    input logic wr, input logic one,
                                    input logic start_of_packet_flag);
    // a set in the same cycle as a clear wins
    w1c_flag = set | (cur & ~(wr & one) & ~start_of_packet_flag);
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mc_r <= MASK_CTRL_RST;
    end else if (wr_mc) begin
      mc_r[MC_LOOKAHEAD] <= wd[MC_LOOKAHEAD];
      mc_r[MC_DEFER_DIS] <= wd[MC_DEFER_DIS];
      mc_r[MC_MOD_BACKOFF] <= wd[MC_MOD_BACKOFF];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      first_feat_wr_r <= 1'b1;
      feat_r[FT_TEST] <= FEATURES_RST[FT_TEST];
    end else if (wr_feat) begin
      first_feat_wr_r <= 1'b0;
      // only the first write may raise it; a zero locks it clear
      feat_r[FT_TEST] <= wd[FT_TEST] & (first_feat_wr_r | feat_r[FT_TEST]);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      feat_r[FT_BURST_DIS:FT_STRIP] <= FEATURES_RST[FT_BURST_DIS:FT_STRIP];
      feat_r[FT_MISS_MASK] <= FEATURES_RST[FT_MISS_MASK];
      feat_r[FT_COL_MASK] <= FEATURES_RST[FT_COL_MASK];
      feat_r[FT_TXS_MASK] <= FEATURES_RST[FT_TXS_MASK];
      feat_r[FT_JAB_MASK] <= FEATURES_RST[FT_JAB_MASK];
    end else if (wr_feat) begin
      feat_r[FT_BURST_DIS:FT_STRIP] <= wd[FT_BURST_DIS:FT_STRIP];
      feat_r[FT_MISS_MASK] <= wd[FT_MISS_MASK];
      feat_r[FT_COL_MASK] <= wd[FT_COL_MASK];
      feat_r[FT_TXS_MASK] <= wd[FT_TXS_MASK];
      feat_r[FT_JAB_MASK] <= wd[FT_JAB_MASK];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      feat_r[FT_MISS_OVF] <= 1'b0;
      feat_r[FT_COL_OVF] <= 1'b0;
      feat_r[FT_TXS] <= 1'b0;
      feat_r[FT_JAB] <= 1'b0;
    end else begin
      feat_r[FT_MISS_OVF] <= w1c_flag(feat_r[FT_MISS_OVF], evt.miss_ovf,
        wr_feat, wd[FT_MISS_OVF], stop_r);
      feat_r[FT_COL_OVF] <= w1c_flag(feat_r[FT_COL_OVF], evt.col_ovf,
        wr_feat, wd[FT_COL_OVF], stop_r);
      feat_r[FT_TXS] <= w1c_flag(feat_r[FT_TXS], evt.tx_start,
        wr_feat, wd[FT_TXS], stop_r);
      feat_r[FT_JAB] <= w1c_flag(feat_r[FT_JAB],
        evt.jabber & evt.twisted_pair, wr_feat, wd[FT_JAB], stop_r);
    end
  end

  // reserved bits hold zero
  always_ff @(posedge aclk) begin
    feat_r[7:6] <= 2'b00;
  end

  // stop follows the core level; a stop write only pulses it one cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stop_r <= 1'b1;
    end else begin
      stop_r <= stop_req | (wr_stat & wd[ST_STOP]);
    end
  end

  logic rx_int_set;
  assign rx_int_set = evt.rx_last_done |
    (evt.rx_first_done & mc_r[MC_LOOKAHEAD]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_int_r <= 1'b0;
    end else begin
      rx_int_r <= w1c_flag(rx_int_r, rx_int_set, wr_stat, wd[ST_RX_INT],
        stop_r);
    end
  end

  // demand is dropped when transmitter is off or a descriptor is fetched
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      demand_r <= 1'b0;
    end else if (stop_r || !transmitter_on) begin
      demand_r <= 1'b0;
    end else if (wr_stat && wd[ST_TX_DEMAND]) begin
      demand_r <= 1'b1;
    end else if (tx_desc_fetched) begin
      demand_r <= 1'b0;
    end
  end

  // ************************************************************
  // start-of-packet scan
  // ************************************************************
  rlf_scan_t scan_r;
  logic [rlf_pkg::RING_IDX_W-1:0] idx_r;
  logic [31:0] poll_cnt_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scan_r <= SC_IDLE;
      idx_r <= '0;
      desc_fetch <= 1'b0;
      desc_own_clear <= 1'b0;
      rx_buffer_ready <= 1'b0;
      poll_cnt_r <= 32'h00000000;
    end else begin
      desc_own_clear <= 1'b0;
      case (scan_r)
        SC_IDLE: begin
          desc_fetch <= 1'b0;
          if (evt.rx_last_done && mc_r[MC_LOOKAHEAD]) begin
            rx_buffer_ready <= 1'b0;
            idx_r <= idx_r + 1'b1;
            desc_fetch <= 1'b1;
            scan_r <= SC_FETCH;
          end
        end
        SC_FETCH: begin
          if (desc_valid) begin
            desc_fetch <= 1'b0;
            if (desc.start && desc.own) begin
              rx_buffer_ready <= 1'b1;
              scan_r <= SC_HOLD;
            end else if (desc.start) begin
              poll_cnt_r <= 32'h00000000;
              scan_r <= SC_POLL;
            end else begin
              desc_own_clear <= desc.own;
              idx_r <= idx_r + 1'b1;
              desc_fetch <= 1'b1;
            end
          end
        end
        SC_POLL: begin
          if (poll_cnt_r == 32'(POLL_CYCLES - 1)) begin
            desc_fetch <= 1'b1;
            scan_r <= SC_FETCH;
          end else begin
            poll_cnt_r <= poll_cnt_r + 32'h00000001;
          end
        end
        SC_HOLD: begin
          // descriptor stays held until the next frame ends
          if (evt.rx_last_done) begin
            scan_r <= SC_IDLE;
          end
        end
        default: scan_r <= SC_IDLE;
      endcase
    end
  end

  // ************************************************************
  // outputs to datapath
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= '0;
      tx_checksum_append <= 1'b1;
      tx_auto_poll <= 1'b0;
      tx_demand_poll <= 1'b0;
      ring_idx <= '0;
    end else begin
      ctrl.lookahead <= mc_r[MC_LOOKAHEAD];
      ctrl.defer_dis <= mc_r[MC_DEFER_DIS];
      ctrl.mod_backoff <= mc_r[MC_MOD_BACKOFF];
      ctrl.test_mode <= feat_r[FT_TEST];
      ctrl.burst_dis <= feat_r[FT_BURST_DIS];
      ctrl.timer_en <= feat_r[FT_TIMER];
      ctrl.poll_dis <= feat_r[FT_POLL_DIS];
      ctrl.auto_pad <= feat_r[FT_PAD];
      ctrl.auto_strip <= feat_r[FT_STRIP];
      // auto pad forces the checksum on whatever the frame asks
      tx_checksum_append <= feat_r[FT_PAD] | ~tx_checksum_disable;
      tx_auto_poll <= transmitter_on & ~feat_r[FT_POLL_DIS];
      tx_demand_poll <= transmitter_on & demand_r;
      ring_idx <= idx_r;
    end
  end

  logic summary_nxt;
  assign summary_nxt =
    (feat_r[FT_MISS_OVF] & ~feat_r[FT_MISS_MASK]) |
    (feat_r[FT_COL_OVF] & ~feat_r[FT_COL_MASK]) |
    (feat_r[FT_TXS] & ~feat_r[FT_TXS_MASK]) |
    (feat_r[FT_JAB] & ~feat_r[FT_JAB_MASK]) |
    rx_int_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      interrupt_summary <= 1'b0;
    end else begin
      interrupt_summary <= summary_nxt;
    end
  end

  // ************************************************************
  // read channel
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        if ({s_axi_araddr[11:2], 2'b00} == OFS_FEATURES) begin
          s_axi_rdata <= {16'h0000, feat_r};
        end else if ({s_axi_araddr[11:2], 2'b00} == OFS_MASK_CTRL) begin
          s_axi_rdata <= {16'h0000, mc_r};
        end else if ({s_axi_araddr[11:2], 2'b00} == OFS_STATUS) begin
          s_axi_rdata <= {28'h0000000, stop_r, demand_r, rx_int_r,
            summary_nxt};
        end else if ({s_axi_araddr[11:2], 2'b00} == OFS_RING) begin
          s_axi_rdata <= {21'h000000, scan_r, idx_r};
        end else begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// ### tb/rlf_ctrl_props.sv
// assertion checker for the rx look-ahead feature control block
`timescale 1ns/100ps
module rlf_ctrl_props #(
  parameter int POLL_CYCLES = 4096
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire rlf_pkg::rlf_evt_t evt,
  input wire logic stop_req,
  input wire logic transmitter_on,
  input wire logic tx_checksum_disable,
  input wire logic desc_valid,
  input wire rlf_pkg::rlf_desc_t desc,
  input wire logic desc_fetch,
  input wire logic desc_own_clear,
  input wire logic rx_buffer_ready,
  input wire rlf_pkg::rlf_ctrl_t ctrl,
  input wire logic tx_checksum_append,
  input wire logic tx_auto_poll,
  input wire logic tx_demand_poll,
  input wire logic [rlf_pkg::RING_IDX_W-1:0] ring_idx,
  input wire logic interrupt_summary
);
  import rlf_pkg::*;
  logic ans;
  logic clr_cause;
  assign ans = desc_valid && desc_fetch;
  assign clr_cause = ans && desc.own && !desc.start;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ****************************************
  // scan and interrupt sequences
  // ****************************************
  sequence s_la_first;
    evt.rx_first_done && ctrl.lookahead && !stop_req ##1
      ctrl.lookahead && !stop_req;
  endsequence
  sequence s_last;
    evt.rx_last_done && !stop_req ##1 !stop_req;
  endsequence
  // poll span kept under 1000 cycles: only small POLL_CYCLES fit
  sequence s_poll_wait;
    !desc_fetch [*2] ##[1:1000] desc_fetch;
  endsequence
  la_first_int_a: assert property (
    s_la_first |-> ##[0:1] interrupt_summary)
    else $error("first buffer raised no interrupt");
  last_int_a: assert property (
    s_last |-> ##[0:1] interrupt_summary)
    else $error("last buffer raised no interrupt");
  fetch_hold_a: assert property (
    desc_fetch && !desc_valid |=> desc_fetch)
    else $error("fetch dropped before answer");
  own_clear_a: assert property (
    desc_own_clear |-> $past(clr_cause))
    else $error("own cleared without cause");
  skip_next_a: assert property (
    ans && !desc.start |-> ##[1:3] desc_fetch)
    else $error("scan did not advance");
  poll_wait_a: assert property (
    ans && desc.start && !desc.own |=> s_poll_wait)
    else $error("host start entry not polled");
  hold_ready_a: assert property (
    ans && desc.start && desc.own |=> ##[0:1] rx_buffer_ready)
    else $error("owned start entry not held");
  reset_ctrl_a: assert property (
    $rose(aresetn) |-> ctrl == '0 && tx_checksum_append)
    else $error("controls wrong after reset");
  pad_append_a: assert property (
    $past(aresetn) |->
      tx_checksum_append == (ctrl.auto_pad || !$past(tx_checksum_disable)))
    else $error("checksum append wrong");
  auto_poll_a: assert property (
    $past(aresetn) |->
      tx_auto_poll == ($past(transmitter_on) && !ctrl.poll_dis))
    else $error("auto poll wrong");
  bvalid_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  // the index output lags the scan by one cycle
  ring_step_a: assert property (
    ans && !desc.start |=> ##1 ring_idx == $past(ring_idx) + 1'b1)
    else $error("ring index did not step");
  demand_gate_a: assert property (
    tx_demand_poll |-> $past(transmitter_on))
    else $error("demand poll while transmitter off");
  ctrl_on_write_a: assert property (
    !$stable(ctrl) |-> $past(s_axi_bvalid))
    else $error("controls moved without a write");
endmodule
bind rlf_ctrl rlf_ctrl_props #(.POLL_CYCLES(POLL_CYCLES)) u_props (
  .aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .evt, .stop_req,
  .transmitter_on, .tx_checksum_disable, .desc_valid, .desc, .desc_fetch,
  .desc_own_clear, .rx_buffer_ready, .ctrl, .tx_checksum_append,
  .tx_auto_poll, .tx_demand_poll, .ring_idx, .interrupt_summary
);

// ### tb/testbench.sv
// self-checking bench for the rx look-ahead feature control block
`timescale 1ns/100ps
module testbench;
  import rlf_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, stop_req = 1'b0;
  logic transmitter_on = 1'b0, tx_desc_fetched = 1'b0, desc_valid = 1'b0;
  logic tx_checksum_disable = 1'b0;
  rlf_evt_t evt = '0;
  rlf_desc_t desc = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, desc_fetch, desc_own_clear, rx_buffer_ready;
  logic tx_checksum_append, tx_auto_poll, tx_demand_poll, interrupt_summary;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [RING_IDX_W-1:0] ring_idx;
  rlf_ctrl_t ctrl;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [33:0] rexp;
  logic [1:0] bexp;
  int fails = 0;
  int checks_done = 0;
  int cyc = 0;
  rlf_ctrl #(.POLL_CYCLES(8)) dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .evt, .stop_req, .transmitter_on, .tx_desc_fetched,
    .tx_checksum_disable, .desc_valid, .desc, .desc_fetch, .desc_own_clear,
    .ring_idx, .rx_buffer_ready, .ctrl, .tx_checksum_append, .tx_auto_poll,
    .tx_demand_poll, .interrupt_summary
  );
  initial begin
    forever #2 aclk = ~aclk;
  end
  task automatic complete_run();
    if (fails == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ****************************************
  // response monitor and hang guard
  // ****************************************
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      $display("Error t=%0t run timed out", $time);
      complete_run();
    end
    if (s_axi_rvalid && s_axi_rready) begin
      rexp = rq.pop_front();
      checks_done++;
      if ({s_axi_rresp, s_axi_rdata} !== rexp) begin
        fails++;
        $display("Error t=%0t read %h want %h", $time,
                 {s_axi_rresp, s_axi_rdata}, rexp);
      end
    end
    if (s_axi_bvalid && s_axi_bready) begin
      bexp = bq.pop_front();
      checks_done++;
      if (s_axi_bresp !== bexp) begin
        fails++;
        $display("Error t=%0t bresp %h want %h", $time, s_axi_bresp, bexp);
      end
    end
  end
  // side inputs wander at random so the pass-through paths get exercised
  always @(posedge aclk) begin
    transmitter_on <= 1'($urandom);
    tx_checksum_disable <= 1'($urandom);
    tx_desc_fetched <= ($urandom % 8) == 0;
  end
  // ****************************************
  // bus, event and descriptor drivers
  // ****************************************
  task automatic wr(input logic [11:0] a, input logic [15:0] d,
                    input logic [1:0] r);
    logic aw_d;
    logic w_d;
    aw_d = 1'b0;
    w_d = 1'b0;
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0, d};
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_d && w_d)) begin
      @(posedge aclk);
      if (s_axi_awready) begin
        aw_d = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready) begin
        w_d = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    rq.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic pulse_evt(input rlf_evt_t e);
    evt <= e;
    @(posedge aclk);
    evt <= '0;
    @(posedge aclk);
  endtask
  task automatic stop_pulse();
    stop_req <= 1'b1;
    @(posedge aclk);
    stop_req <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic answer(input logic own, input logic start);
    do @(posedge aclk); while (!desc_fetch);
    desc_valid <= 1'b1;
    desc <= {own, start};
    @(posedge aclk);
    desc_valid <= 1'b0;
    desc <= {!own, !start};
  endtask
  initial begin
    logic [15:0] v;
    logic [15:0] f;
    logic [15:0] b;
    void'($urandom(32'h6C72));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(OFS_FEATURES, 32'(FEATURES_RST), RESP_OKAY);
    rd(OFS_MASK_CTRL, 32'(MASK_CTRL_RST), RESP_OKAY);
    v = 16'(($urandom & 32'h7D15) | 32'h8000);
    wr(OFS_FEATURES, v, RESP_OKAY);
    rd(OFS_FEATURES, {16'h0, v}, RESP_OKAY);
    wr(OFS_FEATURES, v & 16'h7FFF, RESP_OKAY);
    wr(OFS_FEATURES, v, RESP_OKAY);
    rd(OFS_FEATURES, {16'h0, v & 16'h7FFF}, RESP_OKAY);
    f = 16'($urandom & 32'h18) | 16'h0020;
    wr(OFS_MASK_CTRL, f, RESP_OKAY);
    stop_pulse();
    rd(OFS_MASK_CTRL, {16'h0, f}, RESP_OKAY);
    rd(OFS_FEATURES, {16'h0, v & 16'h7FFF}, RESP_OKAY);
    pulse_evt(rlf_evt_t'(7'h01));
    answer(1'b1, 1'b0);
    answer(1'b0, 1'b0);
    answer(1'b0, 1'b1);
    answer(1'b1, 1'b1);
    rd(OFS_RING, 32'({SC_HOLD, 7'd3}), RESP_OKAY);
    // the stop bit reads the core stop level, which is low here
    rd(OFS_STATUS, 32'h00000003, RESP_OKAY);
    wr(OFS_STATUS, 16'h0002, RESP_OKAY);
    rd(OFS_STATUS, 32'h00000000, RESP_OKAY);
    pulse_evt(rlf_evt_t'(7'h02));
    rd(OFS_STATUS, 32'h00000003, RESP_OKAY);
    b = v & 16'h7C00;
    wr(OFS_FEATURES, b, RESP_OKAY);
    wr(OFS_STATUS, 16'h0002, RESP_OKAY);
    pulse_evt(rlf_evt_t'(7'h7C));
    rd(OFS_FEATURES, {16'h0, b | 16'h022A}, RESP_OKAY);
    rd(OFS_STATUS, 32'h00000001, RESP_OKAY);
    wr(OFS_FEATURES, b | 16'h0208, RESP_OKAY);
    rd(OFS_FEATURES, {16'h0, b | 16'h0022}, RESP_OKAY);
    stop_pulse();
    rd(OFS_FEATURES, {16'h0, b}, RESP_OKAY);
    pulse_evt(rlf_evt_t'(7'h08));
    rd(OFS_FEATURES, {16'h0, b}, RESP_OKAY);
    wr(OFS_FEATURES, b | 16'h0004, RESP_OKAY);
    pulse_evt(rlf_evt_t'(7'h10));
    rd(OFS_FEATURES, {16'h0, b | 16'h000C}, RESP_OKAY);
    rd(OFS_STATUS, 32'h00000000, RESP_OKAY);
    wr(OFS_STATUS, 16'h0004, RESP_OKAY);
    wr(12'h0FC, 16'hFFFF, RESP_SLVERR);
    rd(12'h0FC, 32'h0, RESP_SLVERR);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(OFS_FEATURES, 32'(FEATURES_RST), RESP_OKAY);
    rd(OFS_MASK_CTRL, 32'(MASK_CTRL_RST), RESP_OKAY);
    wr(OFS_FEATURES, 16'h8115, RESP_OKAY);
    rd(OFS_FEATURES, 32'h00008115, RESP_OKAY);
    complete_run();
  end
endmodule
